// >>> hdl/spimsc_pkg.sv
// Purpose: Shared constants and types of the serial peripheral core.
// Assumes: One 10 MHz system clock; registers sit on aligned 32-bit words.
// Notes:   Offsets are byte addresses on the plain register port.

package spimsc_pkg;

    // Register byte offsets.
    localparam logic [4:0] ADR_RXDATA  = 5'h00;
    localparam logic [4:0] ADR_TXDATA  = 5'h04;
    localparam logic [4:0] ADR_STATUS  = 5'h08;
    localparam logic [4:0] ADR_CONTROL = 5'h0c;
    localparam logic [4:0] ADR_SLVSEL  = 5'h14;

    // Status register bit positions.
    localparam int ST_ROE  = 3;
    localparam int ST_TOE  = 4;
    localparam int ST_TMT  = 5;
    localparam int ST_TRDY = 6;
    localparam int ST_RECEIVE_READY_FLAG = 7;
    localparam int ST_E    = 8;

    // Control register bit positions, each enabling the matching status bit.
    localparam int CT_IROE  = 3;
    localparam int CT_ITOE  = 4;
    localparam int CT_ITMT  = 5;
    localparam int CT_ITRDY = 6;
    localparam int CT_IRRDY = 7;
    localparam int CT_IE    = 8;
    localparam int CTRL_W   = 9;

    // Reset values.
    localparam logic [8:0]  CTRL_RST   = 9'h000;
    localparam logic [31:0] SLVSEL_RST = 32'h0000_0001;

    // Serial clock derivation: divisor is the smallest even value that keeps
    // the serial clock at or below the target rate.
    localparam int SYS_CLK_HZ     = 10_000_000;
    localparam int SCLK_TARGET_HZ = 2_500_000;
    localparam int SCLK_DIV       = 2 * ((SYS_CLK_HZ + 2 * SCLK_TARGET_HZ - 1)
                                         / (2 * SCLK_TARGET_HZ));

    // Bit counter width; holds counts up to 32.
    localparam int CNT_W = 6;

    // Transfer engine states.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_XFER,
        ST_TAIL
    } spimsc_state_t;

endpackage

// >>> hdl/spimsc_edge.sv
// Purpose: Serial clock edge source for the serial peripheral core.
// Assumes: Master role divides the system clock; slave role samples the
//          incoming serial clock as a synchronous input.
// Notes:   Leading edge leaves the idle level, trailing edge returns to it.

module spimsc_edge #(
    parameter bit IS_MASTER = 1'b1,
    parameter bit CPOL      = 1'b0,
    parameter int CLK_DIV   = spimsc_pkg::SCLK_DIV
) (
    // Clock and reset.
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    // Control and serial clock in.
    input  wire logic run_i,
    input  wire logic sclk_i,
    // Edge pulses and generated serial clock.
    output logic      lead_o,
    output logic      trail_o,
    output logic      sclk_o
);

    localparam int HALF = CLK_DIV / 2;

    typedef struct packed {
        logic [15:0] cnt;
        logic        phase;
        logic        prev;
    } spimsc_edge_t;

    spimsc_edge_t state_ff;
    spimsc_edge_t nxt_state;
    logic         toggle;

    if (CLK_DIV < 2 || CLK_DIV % 2 != 0 || HALF > 65535) begin : g_bad_div
        $error("Serial clock divisor must be even and at least two.");
    end

    // Divider in master role, edge detector in slave role.
    always_comb begin
        nxt_state = state_ff;
        toggle    = 1'b0;
        lead_o    = 1'b0;
        trail_o   = 1'b0;
        nxt_state.prev = sclk_i;
        if (IS_MASTER) begin
            // Stopping the divider parks the clock at its idle level.
            if (!run_i) begin
                nxt_state.cnt   = 16'h0000;
                nxt_state.phase = 1'b0;
            end else if (state_ff.cnt == 16'(HALF - 1)) begin
                nxt_state.cnt   = 16'h0000;
                nxt_state.phase = !state_ff.phase;
                toggle          = 1'b1;
            end else begin
                nxt_state.cnt = state_ff.cnt + 16'h0001;
            end
            lead_o  = toggle && !state_ff.phase;
            trail_o = toggle && state_ff.phase;
        end else begin
            lead_o  = (sclk_i != state_ff.prev) && (sclk_i != CPOL);
            trail_o = (sclk_i != state_ff.prev) && (sclk_i == CPOL);
        end
    end

    // State register.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_ff <= '{cnt: 16'h0000, phase: 1'b0, prev: CPOL};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign sclk_o = CPOL ^ state_ff.phase;

endmodule

// >>> hdl/spimsc_core.sv
// Purpose: Serial peripheral core, master or slave, with double buffering.
// Assumes: All inputs are synchronous to SYS_CLK_I.
// Notes:   Registers: rxdata, txdata, status, control, slave select.
//
// Functional notes
// - Role fixed by parameter, never changed live.
// - Master has one active-low select per slave.
// - Transmit registers share width n, 1 to 32.
// - Receive registers share the same width n.
// - Idle shifter reloads automatically from transmit holding.
// - Transmit holding accepts writes while shifting.
// - Transmit shifter drives mosi or miso by role.
// - Bit order MSB or LSB first, fixed.
// - Completed word moves into receive holding.
// - Receive holding keeps old word during shift.
// - Receive shifter fed from miso or mosi.
// - Enableable interrupts for receive and transmit ready.
// - Full duplex, one bit each way per serial clock cycle.
// - Runs on bus clock; master divides it.
// - Slave capture timed by incoming serial clock.
// - Master asserts every select set in mask.
// - Bus port offers flow control for DMA.
// - Slave starts shifting once select asserts.
// - Phase picks sample and change edges.
// - Receive ready set on word, cleared by read.

module spimsc_core #(
    parameter bit IS_MASTER = 1'b1,
    parameter int NUM_SS    = 1,
    parameter int WIDTH     = 8,
    parameter bit LSB_FIRST = 1'b0,
    parameter bit CPOL      = 1'b0,
    parameter bit CPHA      = 1'b0,
    parameter int CLK_DIV   = spimsc_pkg::SCLK_DIV
) (
    // Clock and reset.
    input  wire logic              SYS_CLK_I,
    input  wire logic              RST_I,
    // Register port.
    input  wire logic [4:0]        ADDR_I,
    input  wire logic [31:0]       WDATA_I,
    input  wire logic              WR_I,
    input  wire logic              RD_I,
    output logic      [31:0]       RDATA_O,
    // Flow control and interrupt.
    output logic                   READYFORDATA_O,
    output logic                   DATAAVAILABLE_O,
    output logic                   IRQ_O,
    // Master role serial pins.
    output logic                   SCLK_O,
    output logic      [NUM_SS-1:0] SS_N_O,
    output logic                   MOSI_O,
    input  wire logic              MISO_I,
    // Slave role serial pins.
    input  wire logic              SCLK_I,
    input  wire logic              SS_N_I,
    input  wire logic              MOSI_I,
    output logic                   MISO_O
);

    localparam int CW = spimsc_pkg::CNT_W;

    typedef struct packed {
        spimsc_pkg::spimsc_state_t        fsm;
        logic [WIDTH-1:0]                 tx_hold;
        logic [WIDTH-1:0]                 tx_shift;
        logic [WIDTH-1:0]                 rx_shift;
        logic [WIDTH-1:0]                 rx_hold;
        logic                             tx_full;
        logic                             sh_valid;
        logic                             receive_ready_flag;
        logic                             roe;
        logic                             toe;
        logic [CW-1:0]                    cnt;
        logic [spimsc_pkg::CTRL_W-1:0]    ctrl;
        logic [NUM_SS-1:0]                slvsel;
        logic [NUM_SS-1:0]                ss_n;
        logic                             ser_out;
        logic [31:0]                      rd_data;
    } spimsc_core_t;

    spimsc_core_t state_ff;
    spimsc_core_t nxt_state;

    logic        lead;
    logic        trail;
    logic        sclk_gen;
    logic        run;
    logic        smp;
    logic        chg;
    logic        in_bit;
    logic        sel;
    logic        done;
    logic        load;
    logic        tmt;
    logic        trdy;
    logic [31:0] status_w;

    // Parameter ranges the datapath can serve.
    if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
        $error("Data width must lie between 1 and 32.");
    end
    if (NUM_SS < 1 || NUM_SS > 32) begin : g_bad_ss
        $error("Select count must lie between 1 and 32.");
    end

    // Address match, shared by every strobe decode.
    function automatic logic hit(input logic [4:0] adr,
                                 input logic [4:0] off);
        hit = (adr == off);
    endfunction

    // Next transmit word after one bit has left.
    function automatic logic [WIDTH-1:0] shift_out(input logic [WIDTH-1:0] v);
        if (LSB_FIRST) begin
            shift_out = v >> 1;
        end else begin
            shift_out = v << 1;
        end
    endfunction

    // Receive word with one more bit taken in, same order as transmit.
    function automatic logic [WIDTH-1:0] shift_in(input logic [WIDTH-1:0] v,
                                                  input logic             b);
        if (LSB_FIRST) begin
            shift_in = (v >> 1) | (WIDTH'(b) << (WIDTH - 1));
        end else begin
            shift_in = (v << 1) | WIDTH'(b);
        end
    endfunction

    // Bit currently presented on the serial output.
    function automatic logic head_bit(input logic [WIDTH-1:0] v);
        head_bit = LSB_FIRST ? v[0] : v[WIDTH-1];
    endfunction

    // Edge source: divider when master, sampled input clock when slave.
    assign run = IS_MASTER && (state_ff.fsm != spimsc_pkg::ST_IDLE);

    spimsc_edge #(
        .IS_MASTER (IS_MASTER),
        .CPOL      (CPOL),
        .CLK_DIV   (CLK_DIV)
    ) u_edge (
        .sys_clk_i (SYS_CLK_I),
        .rst_i     (RST_I),
        .run_i     (run),
        .sclk_i    (SCLK_I),
        .lead_o    (lead),
        .trail_o   (trail),
        .sclk_o    (sclk_gen)
    );

    // Status view, used by the read mux and the interrupt.
    assign tmt  = (state_ff.fsm == spimsc_pkg::ST_IDLE) && !state_ff.sh_valid;
    assign trdy = !state_ff.tx_full;

    always_comb begin
        status_w = 32'h0000_0000;
        status_w[spimsc_pkg::ST_ROE]  = state_ff.roe;
        status_w[spimsc_pkg::ST_TOE]  = state_ff.toe;
        status_w[spimsc_pkg::ST_TMT]  = tmt;
        status_w[spimsc_pkg::ST_TRDY] = trdy;
        status_w[spimsc_pkg::ST_RECEIVE_READY_FLAG] = state_ff.receive_ready_flag;
        status_w[spimsc_pkg::ST_E]    = state_ff.roe | state_ff.toe;
    end

    // Whole next-state computation. Software clears are applied first and
    // hardware sets afterwards, so an event in the clearing cycle survives.
    always_comb begin
        nxt_state = state_ff;
        done      = 1'b0;
        load      = 1'b0;
        // Role is a constant; nothing written by software can change it.
        in_bit = IS_MASTER ? MISO_I : MOSI_I;
        sel    = !IS_MASTER && !SS_N_I;
        // Phase 0 samples on leading edges, phase 1 on trailing edges.
        smp = CPHA ? trail : lead;
        chg = CPHA ? lead : trail;

        // Software side clears and register writes.
        if (RD_I && hit(ADDR_I, spimsc_pkg::ADR_RXDATA)) begin
            nxt_state.receive_ready_flag = 1'b0;
        end
        if (WR_I && hit(ADDR_I, spimsc_pkg::ADR_STATUS)) begin
            nxt_state.roe = 1'b0;
            nxt_state.toe = 1'b0;
        end
        if (WR_I && hit(ADDR_I, spimsc_pkg::ADR_CONTROL)) begin
            nxt_state.ctrl = WDATA_I[spimsc_pkg::CTRL_W-1:0];
        end
        if (WR_I && hit(ADDR_I, spimsc_pkg::ADR_SLVSEL)) begin
            nxt_state.slvsel = WDATA_I[NUM_SS-1:0];
        end

        // Transfer engine. A change edge that comes while the bit count is still zero
        // is skipped, since the first bit is already presented when the word begins.
        case (state_ff.fsm)
            spimsc_pkg::ST_IDLE: begin
                // Master starts once a word sits in the shifter; slave
                // starts as soon as its select is pulled low.
                if (IS_MASTER ? state_ff.sh_valid : sel) begin
                    nxt_state.fsm = spimsc_pkg::ST_XFER;
                    nxt_state.cnt = '0;
                end
            end
            spimsc_pkg::ST_XFER: begin
                if (!IS_MASTER && !sel) begin
                    // Select dropped mid-word: the partial word is dropped.
                    nxt_state.fsm = spimsc_pkg::ST_IDLE;
                end else begin
                    if (chg && state_ff.cnt != '0) begin
                        nxt_state.tx_shift = shift_out(state_ff.tx_shift);
                    end
                    if (smp) begin
                        nxt_state.rx_shift = shift_in(state_ff.rx_shift,
                                                      in_bit);
                        if (state_ff.cnt == CW'(WIDTH - 1)) begin
                            done          = 1'b1;
                            nxt_state.cnt = '0;
                            if (IS_MASTER) begin
                                nxt_state.fsm = CPHA ? spimsc_pkg::ST_IDLE
                                                     : spimsc_pkg::ST_TAIL;
                            end
                        end else begin
                            nxt_state.cnt = state_ff.cnt + CW'(1);
                        end
                    end
                end
            end
            spimsc_pkg::ST_TAIL: begin
                // Master holds select until the last trailing edge.
                if (trail) begin
                    nxt_state.fsm = spimsc_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state.fsm = spimsc_pkg::ST_IDLE;
            end
        endcase

        // Word complete: holding register is only touched here.
        if (done) begin
            nxt_state.rx_hold  = shift_in(state_ff.rx_shift, in_bit);
            nxt_state.receive_ready_flag     = 1'b1;
            nxt_state.sh_valid = 1'b0;
            if (state_ff.receive_ready_flag && !(RD_I && hit(ADDR_I,
                                    spimsc_pkg::ADR_RXDATA))) begin
                nxt_state.roe = 1'b1;
            end
        end

        // Reload the shifter when it is empty and the engine is idle. A slave may also
        // reload at a word boundary while select stays low.
        if (state_ff.tx_full && !nxt_state.sh_valid &&
            (state_ff.fsm == spimsc_pkg::ST_IDLE ||
             (!IS_MASTER && (done || state_ff.cnt == '0)))) begin
            load               = 1'b1;
            nxt_state.tx_shift = state_ff.tx_hold;
            nxt_state.tx_full  = 1'b0;
            nxt_state.sh_valid = 1'b1;
        end

        // Transmit write lands in holding even while a word shifts out; a
        // write over an unsent word is flagged but still taken.
        if (WR_I && hit(ADDR_I, spimsc_pkg::ADR_TXDATA)) begin
            nxt_state.tx_hold = WDATA_I[WIDTH-1:0];
            nxt_state.tx_full = 1'b1;
            if (state_ff.tx_full && !load) begin
                nxt_state.toe = 1'b1;
            end
        end

        // Serial output follows the shifter with no added cycle of lag.
        nxt_state.ser_out = head_bit(nxt_state.tx_shift);

        // Master selects follow the mask for the whole word.
        if (IS_MASTER && nxt_state.fsm != spimsc_pkg::ST_IDLE) begin
            nxt_state.ss_n = ~state_ff.slvsel;
        end else begin
            nxt_state.ss_n = '1;
        end

        // Read data stand only in the cycle after the strobe.
        nxt_state.rd_data = 32'h0000_0000;
        if (RD_I) begin
            if (hit(ADDR_I, spimsc_pkg::ADR_RXDATA)) begin
                nxt_state.rd_data = 32'(state_ff.rx_hold);
            end else if (hit(ADDR_I, spimsc_pkg::ADR_TXDATA)) begin
                nxt_state.rd_data = 32'(state_ff.tx_hold);
            end else if (hit(ADDR_I, spimsc_pkg::ADR_STATUS)) begin
                nxt_state.rd_data = status_w;
            end else if (hit(ADDR_I, spimsc_pkg::ADR_CONTROL)) begin
                nxt_state.rd_data = 32'(state_ff.ctrl);
            end else if (hit(ADDR_I, spimsc_pkg::ADR_SLVSEL)) begin
                nxt_state.rd_data = 32'(state_ff.slvsel);
            end else begin
                nxt_state.rd_data = 32'h0000_0000;
            end
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            state_ff.fsm      <= spimsc_pkg::ST_IDLE;
            state_ff.tx_hold  <= '0;
            state_ff.tx_shift <= '0;
            state_ff.rx_shift <= '0;
            state_ff.rx_hold  <= '0;
            state_ff.tx_full  <= 1'b0;
            state_ff.sh_valid <= 1'b0;
            state_ff.receive_ready_flag     <= 1'b0;
            state_ff.roe      <= 1'b0;
            state_ff.toe      <= 1'b0;
            state_ff.cnt      <= '0;
            state_ff.ctrl     <= spimsc_pkg::CTRL_RST;
            state_ff.slvsel   <= spimsc_pkg::SLVSEL_RST[NUM_SS-1:0];
            state_ff.ss_n     <= '1;
            state_ff.ser_out  <= 1'b0;
            state_ff.rd_data  <= 32'h0000_0000;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Flow control lets a DMA engine pace itself without wait states.
    assign READYFORDATA_O  = trdy;
    assign DATAAVAILABLE_O = state_ff.receive_ready_flag;

    // Level interrupt; it drops once software removes its cause.
    assign IRQ_O = (state_ff.ctrl[spimsc_pkg::CT_IRRDY] & state_ff.receive_ready_flag)
                 | (state_ff.ctrl[spimsc_pkg::CT_ITRDY] & trdy)
                 | (state_ff.ctrl[spimsc_pkg::CT_ITMT]  & tmt)
                 | (state_ff.ctrl[spimsc_pkg::CT_IROE]  & state_ff.roe)
                 | (state_ff.ctrl[spimsc_pkg::CT_ITOE]  & state_ff.toe)
                 | (state_ff.ctrl[spimsc_pkg::CT_IE]
                    & (state_ff.roe | state_ff.toe));

    // Pin drive by role. The slave drives miso even when unselected, so a
    // shared line needs an external buffer gated by select.
    assign RDATA_O = state_ff.rd_data;
    assign SCLK_O  = IS_MASTER ? sclk_gen : CPOL;
    assign SS_N_O  = state_ff.ss_n;
    assign MOSI_O  = IS_MASTER ? state_ff.ser_out : 1'b0;
    assign MISO_O  = IS_MASTER ? 1'b0 : state_ff.ser_out;

endmodule

// >>> bench/spimsc_core_properties.sv
// Purpose: Checker for the serial core's register port and master pins.
// Assumes: Master role, clock polarity 0, phase 0, divisor 4.
// Notes:   Sees only the top module's ports; attached by bind.
module spimsc_core_properties #(
    parameter int NUM_SS = 1
) (
    input wire logic              SYS_CLK_I,
    input wire logic              RST_I,
    input wire logic [4:0]        ADDR_I,
    input wire logic [31:0]       WDATA_I,
    input wire logic              WR_I,
    input wire logic              RD_I,
    input wire logic [31:0]       RDATA_O,
    input wire logic              READYFORDATA_O,
    input wire logic              DATAAVAILABLE_O,
    input wire logic              IRQ_O,
    input wire logic              SCLK_O,
    input wire logic [NUM_SS-1:0] SS_N_O,
    input wire logic              MOSI_O,
    input wire logic              MISO_I,
    input wire logic              SCLK_I,
    input wire logic              SS_N_I,
    input wire logic              MOSI_I,
    input wire logic              MISO_O
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (RST_I);
    logic wtx;
    logic idle;
    // Decodes shared by several properties.
    assign wtx  = WR_I && ADDR_I == spimsc_pkg::ADR_TXDATA;
    assign idle = &SS_N_O;
    rdata_zero_a: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
        else $error("read data seen outside its cycle");
    hold_full_a: assert property (wtx |=> !READYFORDATA_O)
        else $error("holding register not marked full");
    sel_start_a: assert property (
        wtx && idle && READYFORDATA_O |-> ##[1:3] !idle)
        else $error("write did not start a transfer");
    sel_move_a: assert property (
        $changed(SS_N_O) && !idle |-> &$past(SS_N_O))
        else $error("select changed inside a word");
    sclk_idle_a: assert property (idle |-> !SCLK_O)
        else $error("serial clock left idle level");
    sclk_half_a: assert property (
        $rose(SCLK_O) |=> SCLK_O ##1 !SCLK_O)
        else $error("serial clock half period wrong");
    lead_gap_a: assert property (
        $fell(idle) |-> !SCLK_O [*2] ##1 SCLK_O)
        else $error("first leading edge misplaced");
    mosi_move_a: assert property (
        $changed(MOSI_O) && !idle && !$fell(idle) |-> $fell(SCLK_O))
        else $error("data out changed off the trailing edge");
    rx_set_a: assert property (
        $rose(DATAAVAILABLE_O) |-> $rose(SCLK_O))
        else $error("ready flag not after a sample edge");
    rx_clear_a: assert property (
        RD_I && ADDR_I == spimsc_pkg::ADR_RXDATA
        |=> !DATAAVAILABLE_O || $rose(SCLK_O))
        else $error("ready flag not cleared by read");
    // Main scenarios.
    cover property (wtx);
    cover property ($rose(DATAAVAILABLE_O));
    cover property ($rose(IRQ_O));
endmodule

// >>> bench/spimsc_slave_model.sv
// Purpose: Behavioural serial slave facing the core's master pins.
// Assumes: Clock polarity 0, phase 0, eight-bit words, MSB first.
// Notes:   No pull on the return line, so a released line is inverted.
module spimsc_slave_model (
    // Serial pins.
    input  wire logic       sclk_i,
    input  wire logic       ss_n_i,
    input  wire logic       mosi_i,
    output logic            miso_o,
    // Test side.
    input  wire logic [7:0] tx_i,
    output logic      [7:0] rx_o,
    output int              count_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh;
    logic       live;
    // Start in a defined state.
    initial begin
        live    = 1'b0;
        miso_o  = 1'b1;
        rx_o    = 8'h00;
        count_o = 0;
        sh      = 8'h00;
    end
    // First bit goes out the moment the select falls.
    always @(negedge ss_n_i) begin
        live   = 1'b1;
        sh     = tx_i;
        miso_o = tx_i[7];
    end
    // Sample on the leading edge.
    always @(posedge sclk_i) begin
        if (!ss_n_i) begin
            rx_o = {rx_o[6:0], mosi_i};
        end
    end
    // Change on the trailing edge.
    always @(negedge sclk_i) begin
        if (!ss_n_i) begin
            sh     = {sh[6:0], 1'b0};
            miso_o = sh[7];
        end
    end
    // Released line shows the inverse so a stale bit never passes. Only a
    // real release counts; the unknown-to-high step at reset is no frame.
    always @(posedge ss_n_i) begin
        if (live) begin
            live    = 1'b0;
            miso_o  = ~miso_o;
            count_o = count_o + 1;
        end
    end
endmodule

// >>> bench/spimsc_core_tb.sv
// Purpose: Self-checking bench for the serial core in master role.
// Assumes: Eight-bit words, two selects, default divisor.
// Notes:   A behavioural slave sits on select one.
module spimsc_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, wr, rd, irq, sclk, mosi, miso, rfd, dav;
    logic [4:0]  addr;
    logic [31:0] wdata, rdata;
    logic [1:0]  ss_n;
    logic [7:0]  ptx, prx;
    int          pcnt, fails, comparisons;
    spimsc_core #(.NUM_SS(2)) DUT (
        .SYS_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .READYFORDATA_O(rfd),
        .DATAAVAILABLE_O(dav), .IRQ_O(irq), .SCLK_O(sclk), .SS_N_O(ss_n),
        .MOSI_O(mosi), .MISO_I(miso), .SCLK_I(1'b0), .SS_N_I(1'b1),
        .MOSI_I(1'b0), .MISO_O());
    spimsc_slave_model u_slave (.sclk_i(sclk), .ss_n_i(ss_n[1]),
        .mosi_i(mosi), .miso_o(miso), .tx_i(ptx), .rx_o(prx),
        .count_o(pcnt));
    // System clock, 100 ns period.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] a);
        comparisons++;
        if (a !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, a);
            fails++;
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Strobes rise after one edge and fall after the next.
    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] e,
                          input string nm);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(nm, e, rdata);
    endtask
    // Bounded wait: 0 ready, 1 data, 2 deselected, 3 third word.
    task automatic wait_on(input int w);
        int n;
        for (n = 0; n < 500; n++) begin
            @(posedge clk);
            #1;
            if ((w == 0 && rfd === 1'b1) || (w == 1 && dav === 1'b1) ||
                (w == 2 && ss_n === 2'b11) || (w == 3 && pcnt == 3)) return;
        end
        $display("[FAIL] wait %0d expected 1 seen 0", w);
        fails++;
        finish_test();
    endtask
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 5'h00;
        wdata = 32'h0;
        ptx = 8'hc6;
        fails = 0;
        comparisons = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        // Reset values and refused accesses.
        rd_chk(spimsc_pkg::ADR_STATUS, 32'h60, "status");
        rd_chk(spimsc_pkg::ADR_CONTROL, 32'h0, "control");
        rd_chk(spimsc_pkg::ADR_SLVSEL, 32'h1, "mask");
        wr_reg(spimsc_pkg::ADR_RXDATA, 32'hff);
        rd_chk(spimsc_pkg::ADR_RXDATA, 32'h0, "rxdata");
        rd_chk(5'h10, 32'h0, "unmapped");
        $display("test reset done");
        // One full-duplex word to select one.
        wr_reg(spimsc_pkg::ADR_SLVSEL, 32'h2);
        wr_reg(spimsc_pkg::ADR_TXDATA, 32'h35);
        wait_on(1);
        chk("select", 32'h1, {30'h0, ss_n});
        rd_chk(spimsc_pkg::ADR_RXDATA, 32'hc6, "rxdata");
        chk("ready flag", 32'h0, {31'h0, dav});
        wait_on(2);
        chk("slave rx", 32'h35, {24'h0, prx});
        $display("test single word done");
        // Refill while shifting, overrun both ways.
        ptx = 8'h4b;
        wr_reg(spimsc_pkg::ADR_TXDATA, 32'h11);
        wait_on(0);
        wr_reg(spimsc_pkg::ADR_TXDATA, 32'h22);
        wr_reg(spimsc_pkg::ADR_TXDATA, 32'h33);
        rd_chk(spimsc_pkg::ADR_RXDATA, 32'hc6, "old rxdata");
        wait_on(3);
        chk("slave rx", 32'h33, {24'h0, prx});
        rd_chk(spimsc_pkg::ADR_STATUS, 32'h1f8, "status");
        $display("test double buffer done");
        // Interrupt raised, cleared and masked.
        wr_reg(spimsc_pkg::ADR_CONTROL, 32'h80);
        chk("irq", 32'h1, {31'h0, irq});
        rd_chk(spimsc_pkg::ADR_RXDATA, 32'h4b, "rxdata");
        chk("irq", 32'h0, {31'h0, irq});
        wr_reg(spimsc_pkg::ADR_STATUS, 32'h0);
        rd_chk(spimsc_pkg::ADR_STATUS, 32'h60, "status");
        wr_reg(spimsc_pkg::ADR_CONTROL, 32'h40);
        chk("irq", 32'h1, {31'h0, irq});
        wr_reg(spimsc_pkg::ADR_CONTROL, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        $display("test interrupt done");
        finish_test();
    end
endmodule
bind spimsc_core spimsc_core_properties #(.NUM_SS(NUM_SS)) u_props (
    .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .READYFORDATA_O(READYFORDATA_O), .DATAAVAILABLE_O(DATAAVAILABLE_O),
    .IRQ_O(IRQ_O), .SCLK_O(SCLK_O), .SS_N_O(SS_N_O), .MOSI_O(MOSI_O),
    .MISO_I(MISO_I), .SCLK_I(SCLK_I), .SS_N_I(SS_N_I), .MOSI_I(MOSI_I),
    .MISO_O(MISO_O));
